// File: logic/ocg_pkg.sv
// Constants, field layouts and carrier types of the over current / over voltage guard.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
//
// What this block does
// R1 - Over current forces high side, needs both enables
// R2 - Over voltage forces low side, needs both enables
// R3 - Over voltage forces high side, needs both enables
// R4 - Current comparator hysteresis follows its bit
// R5 - Voltage comparator hysteresis follows its bit
// R6 - Amplifier mode bit: 0 inverting, 1 non-inverting
// R7 - Voltage sense pin enabled by its bit
// R8 - Current sense pin enabled by its bit
// R9 - Current debounce: none, 16, 32, 64 clocks
// R10 - Voltage debounce: same encoding, own select
// R11 - Amplifier trim mode: 0 normal, 1 cancellation
// R12 - Amplifier reference: 0 negative, 1 positive input
// R13 - Three 6-bit trims, reset to 100000
// R14 - Voltage comparator trim mode, reference and value
// R15 - Current comparator trim mode, reference and value
// R16 - Amplifier and comparator outputs readable at 2..0
// R17 - Amplifier trim switches decoded from mode, reference
// R18 - Comparator A switches use same decode
// R19 - Comparator B switches use same decode
// R20 - Software calibrates: mode, reference, step, restore
// R21 - Unused status and control bits read zero
// R22 - Forced high side goes high, low side low
// R23 - Event pulses raised; forcing ends with condition
// R24 - Current guard off powers down its analog
// R25 - Voltage guard off powers down its analog
// R26 - Comparator outputs pass two-flop synchronisers
// R27 - Debounce counter restarts on every level change

package ocg_pkg;

   // ********************************
   // Register map (byte addresses)
   // ********************************
   localparam logic [7:0] OCG_ADDR_GUARD_EN = 8'h00;
   localparam logic [7:0] OCG_ADDR_PIN_DB = 8'h04;
   localparam logic [7:0] OCG_ADDR_AMP_TRIM = 8'h08;
   localparam logic [7:0] OCG_ADDR_VCMP_TRIM = 8'h0C;
   localparam logic [7:0] OCG_ADDR_CCMP_TRIM = 8'h10;
   localparam logic [7:0] OCG_ADDR_STATUS = 8'h14;

   // ********************************
   // Field positions
   // ********************************
   localparam int OCG_EN_CUR_GLOBAL = 7;
   localparam int OCG_EN_VOL_GLOBAL = 6;
   localparam int OCG_EN_CUR_LOW = 5;
   localparam int OCG_EN_CUR_HIGH = 4;
   localparam int OCG_EN_VOL_LOW = 3;
   localparam int OCG_EN_VOL_HIGH = 2;
   localparam int OCG_EN_CUR_HYST = 1;
   localparam int OCG_EN_VOL_HYST = 0;
   localparam int OCG_PD_AMP_MODE = 7;
   localparam int OCG_PD_VPIN = 6;
   localparam int OCG_PD_CPIN = 5;
   localparam int OCG_PD_CDB_LSB = 2;
   localparam int OCG_PD_VDB_LSB = 0;
   localparam logic [7:0] OCG_PD_MASK = 8'hEF;
   localparam int OCG_TRIM_MODE = 7;
   localparam int OCG_TRIM_REF = 6;
   localparam int OCG_TRIM_W = 6;
   localparam int OCG_ST_AMP = 2;
   localparam int OCG_ST_CMP_B = 1;
   localparam int OCG_ST_CMP_A = 0;

   // ********************************
   // Reset values
   // ********************************
   localparam logic [7:0] OCG_RST_CTRL = 8'h00;
   localparam logic [7:0] OCG_RST_TRIM = 8'h20;

   // ********************************
   // Timing
   // ********************************
   localparam int OCG_DB_W = 7;
   localparam logic [6:0] OCG_DB_CNT_1 = 7'h10;
   localparam logic [6:0] OCG_DB_CNT_2 = 7'h20;
   localparam logic [6:0] OCG_DB_CNT_3 = 7'h40;

   // AXI write response codes
   localparam logic [1:0] OCG_RESP_OKAY = 2'h0;
   localparam logic [1:0] OCG_RESP_SLVERR = 2'h2;

   // Trim switch set
   typedef struct packed {
      logic one;
      logic two;
      logic three;
   } ocg_switch_t;

   // Trim channel control
   typedef struct packed {
      logic mode;
      logic ref_sel;
      logic [5:0] value;
   } ocg_trim_t;

endpackage : ocg_pkg

// File: logic/ocg_guard.sv
// Over current / over voltage guard: registers, debounce and drive forcing.
// Assumes comparator inputs are asynchronous and the PWM drive arrives on aclk.

`timescale 1ns/100ps
`default_nettype none

module ocg_guard
   import ocg_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog sense outputs, asynchronous
   input wire logic amp_out_raw,
   input wire logic cmp_a_out_raw,
   input wire logic cmp_b_out_raw,
   // PWM drive in and protected drive out
   input wire logic pwm_high_in,
   input wire logic pwm_low_in,
   output logic high_side_drive,
   output logic low_side_drive,
   // Analog controls
   output logic current_analog_on,
   output logic voltage_analog_on,
   output logic current_cmp_hyst_en,
   output logic voltage_cmp_hyst_en,
   output logic amp_polarity_mode,
   output logic voltage_pin_en,
   output logic current_pin_en,
   output ocg_trim_t amp_trim,
   output ocg_trim_t cmp_a_trim,
   output ocg_trim_t cmp_b_trim,
   output ocg_switch_t amp_sw,
   output ocg_switch_t cmp_a_sw,
   output ocg_switch_t cmp_b_sw,
   // Event pulses
   output logic over_voltage_event,
   output logic over_current_event
);

   // ********************************
   // Registers
   // ********************************
   logic [7:0] guard_en;
   logic [7:0] protection_pin_debounce_ctrl;
   logic [7:0] amplifier_offset_trim;
   logic [7:0] voltage_comparator_offset_trim;
   logic [7:0] current_comparator_offset_trim;

   // ********************************
   // Write channel
   // ********************************
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [7:0] w_data;
   logic w_lane0;
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_hit = (aw_addr == OCG_ADDR_GUARD_EN) || (aw_addr == OCG_ADDR_PIN_DB) ||
      (aw_addr == OCG_ADDR_AMP_TRIM) || (aw_addr == OCG_ADDR_VCMP_TRIM) ||
      (aw_addr == OCG_ADDR_CCMP_TRIM) || (aw_addr == OCG_ADDR_STATUS);
   wire wr_en = do_write && w_lane0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= OCG_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !aw_take;
         s_axi_wready <= !w_held && !w_take;
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? OCG_RESP_OKAY : OCG_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_en <= OCG_RST_CTRL;
         protection_pin_debounce_ctrl <= OCG_RST_CTRL;
         amplifier_offset_trim <= OCG_RST_TRIM; // R13
         voltage_comparator_offset_trim <= OCG_RST_TRIM; // R13
         current_comparator_offset_trim <= OCG_RST_TRIM; // R13
      end else if (wr_en) begin
         if (aw_addr == OCG_ADDR_GUARD_EN) guard_en <= w_data;
         if (aw_addr == OCG_ADDR_PIN_DB) protection_pin_debounce_ctrl <= w_data & OCG_PD_MASK; // R21
         if (aw_addr == OCG_ADDR_AMP_TRIM) amplifier_offset_trim <= w_data;
         if (aw_addr == OCG_ADDR_VCMP_TRIM) voltage_comparator_offset_trim <= w_data; // R14
         if (aw_addr == OCG_ADDR_CCMP_TRIM) current_comparator_offset_trim <= w_data; // R15
      end
   end

   // ********************************
   // Synchronisers and debounce
   // ********************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   wire [2:0] raw_in = {amp_out_raw, cmp_b_out_raw, cmp_a_out_raw};
   wire [1:0] db_sel [2];
   wire [1:0] filt;
   assign db_sel[0] = protection_pin_debounce_ctrl[OCG_PD_VDB_LSB +: 2]; // R10
   assign db_sel[1] = protection_pin_debounce_ctrl[OCG_PD_CDB_LSB +: 2]; // R9

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= raw_in; // R26
         sync_b <= sync_a; // R26
      end
   end

   // Channel 0 voltage comparator, channel 1 current comparator
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_db
         logic [OCG_DB_W-1:0] cnt;
         logic last;
         logic flt;
         logic [OCG_DB_W-1:0] target;
         assign filt[gi] = flt;
         always_comb begin
            unique case (db_sel[gi])
               2'b00: target = 7'h00;
               2'b01: target = OCG_DB_CNT_1;
               2'b10: target = OCG_DB_CNT_2;
               2'b11: target = OCG_DB_CNT_3;
            endcase
         end
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt <= 7'h00;
               last <= 1'b0;
               flt <= 1'b0;
            end else begin
               last <= sync_b[gi];
               if (sync_b[gi] != last) begin
                  cnt <= 7'h00; // R27
               end else if (cnt < target) begin
                  cnt <= cnt + 7'h01;
               end
               if (target == 7'h00) begin
                  flt <= sync_b[gi]; // R9 R10
               end else if (sync_b[gi] == last && cnt >= target - 7'h01) begin
                  flt <= sync_b[gi]; // R27
               end
            end
         end
      end
   endgenerate

   // ********************************
   // Forcing
   // ********************************
   wire cur_on = guard_en[OCG_EN_CUR_GLOBAL];
   wire vol_on = guard_en[OCG_EN_VOL_GLOBAL];
   wire vol_fault = vol_on && filt[0]; // R25
   wire cur_fault = cur_on && filt[1]; // R24
   wire force_high = (cur_fault && guard_en[OCG_EN_CUR_HIGH]) || // R1
      (vol_fault && guard_en[OCG_EN_VOL_HIGH]); // R3
   wire force_low = (cur_fault && guard_en[OCG_EN_CUR_LOW]) ||
      (vol_fault && guard_en[OCG_EN_VOL_LOW]); // R2
   logic vol_fault_d;
   logic cur_fault_d;

   // Trim switch decode shared by all three trim channels
   function automatic ocg_switch_t sw_decode(input logic mode, input logic ref_sel);
      sw_decode.one = !mode || ref_sel;
      sw_decode.two = !mode || !ref_sel;
      sw_decode.three = mode;
   endfunction : sw_decode

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_side_drive <= 1'b1;
         low_side_drive <= 1'b0;
         vol_fault_d <= 1'b0;
         cur_fault_d <= 1'b0;
         over_voltage_event <= 1'b0;
         over_current_event <= 1'b0;
         current_analog_on <= 1'b0;
         voltage_analog_on <= 1'b0;
         current_cmp_hyst_en <= 1'b0;
         voltage_cmp_hyst_en <= 1'b0;
         amp_polarity_mode <= 1'b0;
         voltage_pin_en <= 1'b0;
         current_pin_en <= 1'b0;
         amp_trim <= OCG_RST_TRIM;
         cmp_a_trim <= OCG_RST_TRIM;
         cmp_b_trim <= OCG_RST_TRIM;
         amp_sw <= 3'b110;
         cmp_a_sw <= 3'b110;
         cmp_b_sw <= 3'b110;
      end else begin
         high_side_drive <= force_high ? 1'b1 : pwm_high_in; // R22 R23
         low_side_drive <= force_low ? 1'b0 : pwm_low_in; // R22 R23
         vol_fault_d <= vol_fault;
         cur_fault_d <= cur_fault;
         over_voltage_event <= vol_fault && !vol_fault_d; // R23
         over_current_event <= cur_fault && !cur_fault_d; // R23
         current_analog_on <= cur_on; // R24
         voltage_analog_on <= vol_on; // R25
         current_cmp_hyst_en <= guard_en[OCG_EN_CUR_HYST]; // R4
         voltage_cmp_hyst_en <= guard_en[OCG_EN_VOL_HYST]; // R5
         amp_polarity_mode <= protection_pin_debounce_ctrl[OCG_PD_AMP_MODE]; // R6
         voltage_pin_en <= protection_pin_debounce_ctrl[OCG_PD_VPIN]; // R7
         current_pin_en <= protection_pin_debounce_ctrl[OCG_PD_CPIN]; // R8
         amp_trim <= amplifier_offset_trim; // R11 R12
         cmp_a_trim <= voltage_comparator_offset_trim; // R14
         cmp_b_trim <= current_comparator_offset_trim; // R15
         amp_sw <= sw_decode(amplifier_offset_trim[OCG_TRIM_MODE],
            amplifier_offset_trim[OCG_TRIM_REF]); // R17
         cmp_a_sw <= sw_decode(voltage_comparator_offset_trim[OCG_TRIM_MODE],
            voltage_comparator_offset_trim[OCG_TRIM_REF]); // R18
         cmp_b_sw <= sw_decode(current_comparator_offset_trim[OCG_TRIM_MODE],
            current_comparator_offset_trim[OCG_TRIM_REF]); // R19
      end
   end

   // ********************************
   // Read channel
   // ********************************
   wire [7:0] status = {5'h00, sync_b[OCG_ST_AMP], sync_b[OCG_ST_CMP_B],
      sync_b[OCG_ST_CMP_A]}; // R16 R21
   wire rd_hit = (s_axi_araddr[7:2] <= OCG_ADDR_STATUS[7:2]);
   logic [7:0] rd_val;
   always_comb begin
      unique case ({s_axi_araddr[7:2], 2'b00})
         OCG_ADDR_GUARD_EN: rd_val = guard_en;
         OCG_ADDR_PIN_DB: rd_val = protection_pin_debounce_ctrl;
         OCG_ADDR_AMP_TRIM: rd_val = amplifier_offset_trim;
         OCG_ADDR_VCMP_TRIM: rd_val = voltage_comparator_offset_trim;
         OCG_ADDR_CCMP_TRIM: rd_val = current_comparator_offset_trim;
         OCG_ADDR_STATUS: rd_val = status;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= OCG_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? OCG_RESP_OKAY : OCG_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : ocg_guard

`default_nettype wire

// File: tb/ocg_guard_properties.sv
// Port checker of the over current / over voltage guard.
// Assumes binding into ocg_guard with one clock and sync reset.
`timescale 1ns/100ps
`default_nettype none
module ocg_guard_properties
   import ocg_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sense, drive and trims
   input wire logic cmp_b_out_raw,
   input wire logic pwm_high_in,
   input wire logic pwm_low_in,
   input wire logic high_side_drive,
   input wire logic low_side_drive,
   input wire logic current_analog_on,
   input wire logic voltage_analog_on,
   input wire logic over_voltage_event,
   input wire logic over_current_event,
   input wire ocg_trim_t amp_trim,
   input wire ocg_trim_t cmp_a_trim,
   input wire ocg_trim_t cmp_b_trim,
   input wire ocg_switch_t amp_sw,
   input wire ocg_switch_t cmp_a_sw,
   input wire ocg_switch_t cmp_b_sw
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   function automatic ocg_switch_t dec(ocg_trim_t t);
      return !t.mode ? 3'h6 : (t.ref_sel ? 3'h5 : 3'h3);
   endfunction : dec
   sequence held(t);
      $stable(t) ##1 $stable(t);
   endsequence
   AST_AMP_SW: assert property (held(amp_trim) |-> amp_sw == dec(amp_trim))
      else $error("amp switch decode wrong");
   AST_CMPA_SW: assert property (held(cmp_a_trim) |-> cmp_a_sw == dec(cmp_a_trim))
      else $error("comparator A switch decode wrong");
   AST_CMPB_SW: assert property (held(cmp_b_trim) |-> cmp_b_sw == dec(cmp_b_trim))
      else $error("comparator B switch decode wrong");
   AST_RST_TRIM: assert property ($rose(aresetn) |-> amp_trim == OCG_RST_TRIM
      && cmp_a_trim == OCG_RST_TRIM && cmp_b_trim == OCG_RST_TRIM)
      else $error("trim reset value wrong");
   AST_LOW_INACTIVE: assert property (low_side_drive |-> $past(pwm_low_in))
      else $error("low side driven high without drive");
   AST_HIGH_INACTIVE: assert property (!high_side_drive |-> !$past(pwm_high_in))
      else $error("high side driven low without drive");
   AST_NO_FORCE: assert property ((!current_analog_on && !voltage_analog_on) [*2]
      |-> high_side_drive == $past(pwm_high_in) && low_side_drive == $past(pwm_low_in))
      else $error("forcing with both guards off");
   AST_OC_PULSE: assert property (over_current_event |=> !over_current_event)
      else $error("current event longer than one cycle");
   AST_OV_PULSE: assert property (over_voltage_event |=> !over_voltage_event)
      else $error("voltage event longer than one cycle");
   AST_SYNC_DEPTH: assert property ($rose(over_current_event) |-> $past(cmp_b_out_raw, 3))
      else $error("current event too soon after input");
endmodule : ocg_guard_properties
bind ocg_guard ocg_guard_properties u_ocg_guard_properties (.*);
`default_nettype wire

// File: tb/ocg_sense_model.sv
// Behavioural sense path: amplifier and two comparators.
// Assumes levels set by the bench and trims from the guard.
`timescale 1ns/100ps
`default_nettype none
module ocg_sense_model
   import ocg_pkg::*;
#(
   parameter logic [5:0] OFS_POINT = 6'h2A
)
(
   // Trim controls
   input wire ocg_trim_t amp_trim,
   input wire ocg_trim_t cmp_a_trim,
   input wire ocg_trim_t cmp_b_trim,
   // Input levels
   input wire logic amp_lvl,
   input wire logic volt_lvl,
   input wire logic cur_lvl,
   // Digital outputs
   output logic amp_out_raw,
   output logic cmp_a_out_raw,
   output logic cmp_b_out_raw
);
   // Offset cancellation shorts the inputs, output flips at the trim point
   function automatic logic out_of(ocg_trim_t t, logic lvl);
      return t.mode ? (t.value >= OFS_POINT) : lvl;
   endfunction : out_of
   assign amp_out_raw = out_of(amp_trim, amp_lvl);
   assign cmp_a_out_raw = out_of(cmp_a_trim, volt_lvl);
   assign cmp_b_out_raw = out_of(cmp_b_trim, cur_lvl);
endmodule : ocg_sense_model
`default_nettype wire

// File: tb/ocg_guard_tb.sv
// Self-checking bench of the over current / over voltage guard.
// Assumes the sense model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module ocg_guard_tb
   import ocg_pkg::*;
;
   localparam logic [5:0] CAL_POINT = 6'h2A;
   localparam logic [1:0] OK = OCG_RESP_OKAY;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic pwm_high_in = 1'b0, pwm_low_in = 1'b1;
   logic amp_lvl = 1'b0, volt_lvl = 1'b0, cur_lvl = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic amp_out_raw, cmp_a_out_raw, cmp_b_out_raw, high_side_drive, low_side_drive;
   logic current_analog_on, voltage_analog_on, current_cmp_hyst_en, voltage_cmp_hyst_en;
   logic amp_polarity_mode, voltage_pin_en, current_pin_en;
   logic over_voltage_event, over_current_event;
   ocg_trim_t amp_trim, cmp_a_trim, cmp_b_trim;
   ocg_switch_t amp_sw, cmp_a_sw, cmp_b_sw;
   int err_count = 0, n_checks = 0, n_ev = 0;
   wire [1:0] drv = {high_side_drive, low_side_drive};
   wire [1:0] hyst = {current_cmp_hyst_en, voltage_cmp_hyst_en};
   wire [1:0] pwr = {current_analog_on, voltage_analog_on};
   wire [2:0] pins = {amp_polarity_mode, voltage_pin_en, current_pin_en};

   ocg_guard u_ocg_guard (.*);
   ocg_sense_model #(.OFS_POINT(CAL_POINT)) u_ocg_sense_model (.*);

   initial begin
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      n_ev <= n_ev + 32'(over_current_event === 1'b1) + 16 * 32'(over_voltage_event === 1'b1);
   end

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
      @(posedge aclk);
   endtask : wr

   task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic rc(logic [7:0] a, logic [7:0] e, logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk("rdata", d, 32'(e));
      chk("rresp", 32'(r), 32'(er));
   endtask : rc

   task automatic lvl(logic cur, logic v);
      if (cur) cur_lvl <= v;
      else volt_lvl <= v;
   endtask : lvl

   task automatic t_reset();
      rc(OCG_ADDR_AMP_TRIM, OCG_RST_TRIM, OK);
      rc(OCG_ADDR_VCMP_TRIM, OCG_RST_TRIM, OK);
      rc(OCG_ADDR_CCMP_TRIM, OCG_RST_TRIM, OK);
      wr(OCG_ADDR_PIN_DB, 8'hFF, OK);
      rc(OCG_ADDR_PIN_DB, OCG_PD_MASK, OK);
      chk("pins", 32'(pins), 32'h7);
      wr(OCG_ADDR_PIN_DB, 8'h00, OK);
      chk("pins", 32'(pins), 32'h0);
      wr(8'h18, 8'h55, OCG_RESP_SLVERR);
      rc(8'h18, 8'h00, OCG_RESP_SLVERR);
      wr(OCG_ADDR_STATUS, 8'hFF, OK);
      rc(OCG_ADDR_STATUS, 8'h00, OK);
      $display("reset test done");
   endtask : t_reset

   task automatic t_hyst();
      for (int i = 1; i < 3; i++) begin
         wr(OCG_ADDR_GUARD_EN, 8'(i), OK);
         chk("hyst", 32'(hyst), 32'(i));
      end
      $display("hysteresis test done");
   endtask : t_hyst

   task automatic t_trim();
      logic [7:0] v;
      ocg_switch_t e;
      for (int k = 0; k < 4; k++) begin
         v = {2'(k), 6'(k + 5)};
         e = k[1] ? (k[0] ? 3'h5 : 3'h3) : 3'h6;
         wr(OCG_ADDR_AMP_TRIM, v, OK);
         wr(OCG_ADDR_VCMP_TRIM, v, OK);
         wr(OCG_ADDR_CCMP_TRIM, v, OK);
         chk("trim", 32'({amp_trim, cmp_a_trim, cmp_b_trim}), 32'({3{v}}));
         chk("switch", 32'({amp_sw, cmp_a_sw, cmp_b_sw}), 32'({3{e}}));
      end
      $display("trim test done");
   endtask : t_trim

   task automatic t_cal();
      logic [31:0] d;
      logic [1:0] r;
      int v;
      for (v = 0; v < 64; v++) begin
         wr(OCG_ADDR_AMP_TRIM, 8'hC0 | 8'(v), OK);
         repeat (2) @(posedge aclk);
         rd(OCG_ADDR_STATUS, d, r);
         if (d[OCG_ST_AMP] === 1'b1) break;
      end
      chk("cal point", 32'(v), 32'(CAL_POINT));
      wr(OCG_ADDR_AMP_TRIM, {2'b00, CAL_POINT}, OK);
      chk("amp", 32'({amp_trim, amp_sw}), 32'({2'b00, CAL_POINT, 3'h6}));
      wr(OCG_ADDR_VCMP_TRIM, OCG_RST_TRIM, OK);
      wr(OCG_ADDR_CCMP_TRIM, OCG_RST_TRIM, OK);
      $display("calibration test done");
   endtask : t_cal

   task automatic t_force();
      logic [11:0] tbl [7] = '{12'h90F, 12'h80B, 12'h10A, 12'hA09, 12'h481, 12'h447, 12'h0C2};
      logic [31:0] d;
      logic [1:0] r;
      int e0;
      foreach (tbl[i]) begin
         e0 = n_ev;
         wr(OCG_ADDR_GUARD_EN, tbl[i][11:4], OK);
         lvl(tbl[i][3], 1'b1);
         repeat (8) @(posedge aclk);
         chk("drive", 32'(drv), 32'(tbl[i][2:1]));
         chk("analog on", 32'(pwr), 32'(tbl[i][11:10]));
         chk("event", 32'(n_ev - e0), tbl[i][0] ? (tbl[i][3] ? 32'h1 : 32'h10) : 32'h0);
         rd(OCG_ADDR_STATUS, d, r);
         chk("status", d, {30'h0, tbl[i][3], !tbl[i][3]});
         lvl(tbl[i][3], 1'b0);
         repeat (8) @(posedge aclk);
         chk("release", 32'(drv), 32'h1);
      end
      $display("forcing test done");
   endtask : t_force

   task automatic t_deb();
      int n;
      int t;
      int e0;
      wr(OCG_ADDR_GUARD_EN, 8'hD4, OK);
      for (int s = 0; s < 8; s++) begin
         n = (s % 4 == 0) ? 0 : 8 << (s % 4);
         wr(OCG_ADDR_PIN_DB, 8'(s < 4 ? s * 4 : s - 4), OK);
         e0 = n_ev;
         if (n > 0) begin
            repeat (2) begin
               lvl(s < 4, 1'b1);
               repeat (n - 4) @(posedge aclk);
               lvl(s < 4, 1'b0);
               repeat (2) @(posedge aclk);
            end
         end
         chk("glitch", 32'(n_ev - e0), 32'h0);
         lvl(s < 4, 1'b1);
         for (t = 0; t < 90 && high_side_drive !== 1'b1; t++) @(posedge aclk);
         chk("delay", 32'(t >= n && t <= n + 6), 32'h1);
         lvl(s < 4, 1'b0);
         repeat (n + 8) @(posedge aclk);
         chk("recover", 32'(drv), 32'h1);
      end
      $display("debounce test done");
   endtask : t_deb

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (6) @(posedge aclk);
      chk("reset drive", 32'(drv), 32'h2);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_hyst();
      t_trim();
      t_cal();
      t_force();
      t_deb();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      give_verdict();
   end
endmodule : ocg_guard_tb
`default_nettype wire
